// ### inc/oprs_cfg.svh
`ifndef OPRS_CFG_SVH
`define OPRS_CFG_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define OPRS_ADDR_CTRL 4'h0
`define OPRS_ADDR_CONTRAST 4'h1
`define OPRS_ADDR_START 4'h2
`define OPRS_ADDR_COLUMN 4'h3
`define OPRS_ADDR_STATUS 4'h4

// ************************************************************
// Control field positions
// ************************************************************
`define OPRS_CTRL_DISPLAY_ON 0
`define OPRS_CTRL_SEG_REMAP 1
`define OPRS_CTRL_COM_REMAP 2
`define OPRS_CTRL_COM_REVERSE 3

// ************************************************************
// Reset values
// ************************************************************
`define OPRS_RST_CONTRAST 8'h7F
`define OPRS_RST_START 7'h00
`define OPRS_RST_COLUMN 7'h00
`define OPRS_RST_FIRST_COL 7'h00
`define OPRS_RST_FIRST_ROW 7'h00
`define OPRS_RST_DISPLAY_ON 1'h0
`define OPRS_RST_SEG_REMAP 1'h0
`define OPRS_RST_COM_REMAP 1'h0
`define OPRS_RST_COM_REVERSE 1'h0
`define OPRS_RST_RDATA 8'h00

`endif

// ### inc/oprs_pkg.sv
package oprs_pkg;
  // Display geometry modes; only one is supported after reset
  typedef enum logic [1:0] {
    OPRS_MODE_480X128 = 2'h1,
    OPRS_MODE_OTHER = 2'h2
  } oprs_mode_type;

  // Reset capture states
  typedef enum logic [1:0] {
    OPRS_ST_RESET = 2'h1,
    OPRS_ST_RUN = 2'h2
  } oprs_state_type;
endpackage

// ### inc/oprs_sync_if.sv
interface oprs_sync_if;
  logic raw_in;
  logic clean_out;
  modport owner (output raw_in, input clean_out);
  modport sync (input raw_in, output clean_out);
endinterface

// ### src/oprs_pin_sync.sv
module oprs_pin_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Pin path
  oprs_sync_if.sync port
);
  logic stage1;
  logic stage2;
  logic stage3;
  logic level;
  logic next_level;

  // Next filtered level once second and third stage agree
  always_comb begin
    next_level = level;
    if (stage2 == stage3) begin
      next_level = stage3;
    end
  end

  // Three flip-flop chain; reset holds the line at asserted-low
  always_ff @(posedge clk) begin
    if (reset) begin
      stage1 <= 1'h0;
      stage2 <= 1'h0;
      stage3 <= 1'h0;
      level <= 1'h0;
    end else begin
      stage1 <= port.raw_in;
      stage2 <= stage1;
      stage3 <= stage2;
      level <= next_level;
    end
  end

  assign port.clean_out = level;
endmodule

// ### src/oprs_reset_defaults.sv
// Strobed register access and the address map are this design's own decisions.
`include "oprs_cfg.svh"

module oprs_reset_defaults
  import oprs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Hardware reset pin, active low, asynchronous to clk
  input wire logic hw_reset_low,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // Display state
  output logic display_on,
  output oprs_mode_type display_mode,
  output logic seg_remap,
  output logic com_remap,
  output logic com_reverse,
  output logic [6:0] first_segment_driver,
  output logic [6:0] first_common_driver,
  output logic [6:0] start_line,
  output logic [6:0] column_addr,
  output logic [7:0] contrast,
  output logic in_reset
);

  // ************************************************************
  // Pin synchroniser
  // ************************************************************
  oprs_sync_if pin_if ();
  assign pin_if.raw_in = hw_reset_low;
  oprs_pin_sync u_sync (
    .clk(clk),
    .reset(reset),
    .port(pin_if.sync)
  );

  // ************************************************************
  // Register state
  // ************************************************************
  oprs_state_type state;
  oprs_state_type next_state;
  logic next_display_on;
  logic next_seg_remap;
  logic next_com_remap;
  logic next_com_reverse;
  logic [6:0] next_start_line;
  logic [6:0] next_column_addr;
  logic [7:0] next_contrast;
  logic [7:0] next_rdata;
  logic held;
  logic write_ok;

  // Synchronised pin seen low: the block is held in reset
  assign held = ~pin_if.clean_out;

  // Writes land only in run state while the pin is released
  assign write_ok = reg_write && (state == OPRS_ST_RUN) && !held;

  // Decoded read value for an address
  function automatic logic [7:0] read_mux(input logic [3:0] a);
    if (a == `OPRS_ADDR_CTRL) begin
      read_mux = {4'h0, com_reverse, com_remap, seg_remap, display_on};
    end else if (a == `OPRS_ADDR_CONTRAST) begin
      read_mux = contrast;
    end else if (a == `OPRS_ADDR_START) begin
      read_mux = {1'h0, start_line};
    end else if (a == `OPRS_ADDR_COLUMN) begin
      read_mux = {1'h0, column_addr};
    end else if (a == `OPRS_ADDR_STATUS) begin
      read_mux = {7'h00, state == OPRS_ST_RESET};
    end else begin
      read_mux = 8'h00;
    end
  endfunction

  // True when a landing write addresses the given register
  function automatic logic write_hit(input logic strobe, input logic [3:0] a, input logic [3:0] target);
    write_hit = strobe && (a == target);
  endfunction

  // ************************************************************
  // Reset capture state machine
  // ************************************************************
  // Next state: leave reset once the pin is seen released
  always_comb begin
    next_state = state;
    case (state)
      OPRS_ST_RESET: begin
        if (!held) begin
          next_state = OPRS_ST_RUN;
        end
      end
      OPRS_ST_RUN: begin
        if (held) begin
          next_state = OPRS_ST_RESET;
        end
      end
      default: begin
        next_state = OPRS_ST_RESET;
      end
    endcase
  end

  // Register the state
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= OPRS_ST_RESET;
    end else begin
      state <= next_state;
    end
  end

  // ************************************************************
  // Control bits
  // ************************************************************
  // Next control bits: a held pin overrides any write
  always_comb begin
    next_display_on = display_on;
    next_seg_remap = seg_remap;
    next_com_remap = com_remap;
    next_com_reverse = com_reverse;
    if (held) begin
      next_display_on = `OPRS_RST_DISPLAY_ON;
      next_seg_remap = `OPRS_RST_SEG_REMAP;
      next_com_remap = `OPRS_RST_COM_REMAP;
      next_com_reverse = `OPRS_RST_COM_REVERSE;
    end else if (write_hit(write_ok, reg_addr, `OPRS_ADDR_CTRL)) begin
      next_display_on = reg_wdata[`OPRS_CTRL_DISPLAY_ON];
      next_seg_remap = reg_wdata[`OPRS_CTRL_SEG_REMAP];
      next_com_remap = reg_wdata[`OPRS_CTRL_COM_REMAP];
      next_com_reverse = reg_wdata[`OPRS_CTRL_COM_REVERSE];
    end
  end

  // Register the control bits
  always_ff @(posedge clk) begin
    if (reset) begin
      display_on <= `OPRS_RST_DISPLAY_ON;
      seg_remap <= `OPRS_RST_SEG_REMAP;
      com_remap <= `OPRS_RST_COM_REMAP;
      com_reverse <= `OPRS_RST_COM_REVERSE;
    end else begin
      display_on <= next_display_on;
      seg_remap <= next_seg_remap;
      com_remap <= next_com_remap;
      com_reverse <= next_com_reverse;
    end
  end

  // ************************************************************
  // Address pointers
  // ************************************************************
  // Next start line and column: defaults while held, else writes
  always_comb begin
    next_start_line = start_line;
    next_column_addr = column_addr;
    if (held) begin
      next_start_line = `OPRS_RST_START;
      next_column_addr = `OPRS_RST_COLUMN;
    end else if (write_hit(write_ok, reg_addr, `OPRS_ADDR_START)) begin
      next_start_line = reg_wdata[6:0];
    end else if (write_hit(write_ok, reg_addr, `OPRS_ADDR_COLUMN)) begin
      next_column_addr = reg_wdata[6:0];
    end
  end

  // Register the address pointers
  always_ff @(posedge clk) begin
    if (reset) begin
      start_line <= `OPRS_RST_START;
      column_addr <= `OPRS_RST_COLUMN;
    end else begin
      start_line <= next_start_line;
      column_addr <= next_column_addr;
    end
  end

  // ************************************************************
  // Contrast
  // ************************************************************
  // Next contrast: default value while held, else writes
  always_comb begin
    next_contrast = contrast;
    if (held) begin
      next_contrast = `OPRS_RST_CONTRAST;
    end else if (write_hit(write_ok, reg_addr, `OPRS_ADDR_CONTRAST)) begin
      next_contrast = reg_wdata;
    end
  end

  // Register the contrast
  always_ff @(posedge clk) begin
    if (reset) begin
      contrast <= `OPRS_RST_CONTRAST;
    end else begin
      contrast <= next_contrast;
    end
  end

  // ************************************************************
  // Read data
  // ************************************************************
  // Next read data: zero unless a read strobe stands
  always_comb begin
    next_rdata = `OPRS_RST_RDATA;
    if (reg_read) begin
      next_rdata = read_mux(reg_addr);
    end
  end

  // Register the read data, which stands for one cycle after each cycle of read strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= `OPRS_RST_RDATA;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // ************************************************************
  // Fixed outputs and reset status
  // ************************************************************
  // Fixed geometry and address mapping of the first drivers
  assign display_mode = OPRS_MODE_480X128;
  assign first_segment_driver = `OPRS_RST_FIRST_COL;
  assign first_common_driver = `OPRS_RST_FIRST_ROW;
  assign in_reset = (state == OPRS_ST_RESET);
endmodule

// ### testbench/oprs_reset_defaults_sva.sv
module oprs_reset_defaults_sva
  import oprs_pkg::*;
(
  // Clock, reset, register port
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  // Display state
  input wire logic display_on,
  input wire oprs_mode_type display_mode,
  input wire logic com_reverse,
  input wire logic [6:0] first_segment_driver,
  input wire logic [6:0] first_common_driver,
  input wire logic [6:0] start_line,
  input wire logic [6:0] column_addr,
  input wire logic [7:0] contrast,
  input wire logic in_reset
);
  // ************************************************************
  // Defaults while held in reset, and contrast readback
  // ************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_off; in_reset && $past(in_reset) |-> !display_on; endproperty
  a_off: assert property (p_off) else $error("display on in reset");
  property p_mode; display_mode == OPRS_MODE_480X128; endproperty
  a_mode: assert property (p_mode) else $error("wrong mode");
  property p_map; first_segment_driver == 7'h00 && first_common_driver == 7'h00; endproperty
  a_map: assert property (p_map) else $error("mapping moved");
  property p_start; in_reset && $past(in_reset) |-> start_line == 7'h00; endproperty
  a_start: assert property (p_start) else $error("start line set");
  property p_col; in_reset && $past(in_reset) |-> column_addr == 7'h00; endproperty
  a_col: assert property (p_col) else $error("column set");
  property p_scan; in_reset && $past(in_reset) |-> !com_reverse; endproperty
  a_scan: assert property (p_scan) else $error("scan reversed");
  property p_contr; in_reset && $past(in_reset) |-> contrast == 8'h7F; endproperty
  a_contr: assert property (p_contr) else $error("contrast not default");
  property p_rd; reg_read && reg_addr == 4'h1 |=> reg_rdata == $past(contrast); endproperty
  a_rd: assert property (p_rd) else $error("contrast read wrong");
endmodule

bind oprs_reset_defaults oprs_reset_defaults_sva oprs_reset_defaults_sva_inst (.clk, .reset, .reg_addr,
  .reg_read, .reg_rdata, .display_on, .display_mode, .com_reverse, .first_segment_driver,
  .first_common_driver, .start_line, .column_addr, .contrast, .in_reset);

// ### testbench/oprs_host_model.sv
module oprs_host_model #(
  // Settle wait scaled down from the long panel wait to keep runs short
  parameter int CLK_MHZ = 125,
  parameter int WAIT_US = 1,
  parameter int WAIT = CLK_MHZ * WAIT_US
) (
  // Clock, reset, supply requests
  input wire logic clk,
  input wire logic reset,
  input wire logic pin_req,
  input wire logic panel_req,
  // Pin and supply state
  output logic hw_reset_low,
  output logic panel_ready,
  output logic panel_empty
);
  timeunit 1ns;
  timeprecision 1ps;
  int ramp;
  int charge;
  // Logic supplies ramp after reset; pin stays low meanwhile
  always_ff @(posedge clk) begin
    if (reset) ramp <= 0;
    else if (ramp < 4) ramp <= ramp + 1;
  end
  // Panel supply charges while requested and discharges after, one count a cycle
  always_ff @(posedge clk) begin
    if (reset) charge <= 0;
    else if (panel_req && charge < WAIT) charge <= charge + 1;
    else if (!panel_req && charge > 0) charge <= charge - 1;
  end
  assign panel_ready = (charge == WAIT);
  assign panel_empty = (charge == 0);
  // Logic supplies drop on request only once the panel has discharged
  assign hw_reset_low = (ramp >= 4) && !(pin_req && panel_empty);
endmodule

// ### testbench/tb_oprs_reset_defaults.sv
module tb_oprs_reset_defaults;
  import oprs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, reset = 1, pin_req = 0, panel_req = 0, reg_write = 0, reg_read = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, contrast;
  logic hw_reset_low, panel_ready, panel_empty, display_on, seg_remap, com_remap, com_reverse, in_reset;
  logic [6:0] first_segment_driver, first_common_driver, start_line, column_addr;
  oprs_mode_type display_mode;
  int err_total = 0, total_checks = 0;
  oprs_host_model oprs_host_model_inst (.clk, .reset, .pin_req, .panel_req, .hw_reset_low, .panel_ready,
    .panel_empty);
  oprs_reset_defaults oprs_reset_defaults_inst (.clk, .reset, .hw_reset_low, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .display_on, .display_mode, .seg_remap, .com_remap, .com_reverse,
    .first_segment_driver, .first_common_driver, .start_line, .column_addr, .contrast, .in_reset);
  // ************************************************************
  // Shared tasks
  // ************************************************************
  initial begin
    forever #4 clk = ~clk;
  end
  task chk(string n, logic [7:0] e, logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      err_total++;
    end
  endtask
  task wr(logic [3:0] a, logic [7:0] d);
    @(posedge clk) {reg_write, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk) reg_write <= 1'b0;
  endtask
  task rd(logic [3:0] a, logic [7:0] e);
    @(posedge clk) {reg_read, reg_addr} <= {1'b1, a};
    @(posedge clk) reg_read <= 1'b0;
    #1 chk("rdata", e, reg_rdata);
  endtask
  task defaults;
    #1;
    chk("display_on", 8'h00, {7'h00, display_on});
    chk("mode", 8'h01, {6'h00, display_mode});
    chk("seg map", 8'h00, {first_segment_driver, seg_remap});
    chk("com map", 8'h00, {first_common_driver, com_remap});
    chk("start", 8'h00, {1'b0, start_line});
    chk("column", 8'h00, {1'b0, column_addr});
    chk("reverse", 8'h00, {7'h00, com_reverse});
    chk("contrast", 8'h7F, contrast);
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task t_power_up;
    for (int i = 0; i < 40 && in_reset !== 1'b0; i++) @(posedge clk);
    defaults();
    rd(4'h4, 8'h00);
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h7F);
    wr(4'h3, 8'h00);
    @(posedge clk) panel_req <= 1'b1;
    for (int i = 0; i < 300 && panel_ready !== 1'b1; i++) @(posedge clk);
    chk("ready", 8'h01, {7'h00, panel_ready});
    $display("test power_up done");
  endtask
  task t_regs;
    wr(4'h0, 8'h0F);
    wr(4'h1, 8'h33);
    wr(4'h2, 8'h05);
    wr(4'h3, 8'h09);
    rd(4'h1, 8'h33);
    rd(4'h2, 8'h05);
    rd(4'h3, 8'h09);
    rd(4'h7, 8'h00);
    chk("ctrl", 8'h0F, {4'h0, com_reverse, com_remap, seg_remap, display_on});
    $display("test regs done");
  endtask
  task t_pin;
    wr(4'h0, 8'h00);
    #1 chk("display_off", 8'h00, {7'h00, display_on});
    @(posedge clk) panel_req <= 1'b0;
    @(posedge clk) pin_req <= 1'b1;
    repeat (8) @(posedge clk);
    #1 chk("in_reset", 8'h00, {7'h00, in_reset});
    for (int i = 0; i < 300 && in_reset !== 1'b1; i++) @(posedge clk);
    #1 chk("in_reset", 8'h01, {7'h00, in_reset});
    wr(4'h1, 8'h11);
    defaults();
    rd(4'h4, 8'h01);
    @(posedge clk) pin_req <= 1'b0;
    for (int i = 0; i < 20 && in_reset !== 1'b0; i++) @(posedge clk);
    rd(4'h1, 8'h7F);
    $display("test pin done");
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #40000;
    err_total++;
    give_verdict();
  end
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    t_power_up();
    t_regs();
    t_pin();
    give_verdict();
  end
endmodule
